// ### verilog/ale_pkg.sv
`default_nettype none
package ale_pkg;

  // Clock and time figures.
  localparam int unsigned CLK_KHZ          = 125000;
  localparam int unsigned PULSE_PERIOD_US  = 1000;
  localparam int unsigned BLINK_HALF_MS    = 250;
  localparam int unsigned PULSE_HALF_CYC   =
    (PULSE_PERIOD_US * (CLK_KHZ / 1000)) / 2;
  localparam int unsigned BLINK_HALF_CYC   = BLINK_HALF_MS * CLK_KHZ;
  localparam int unsigned CNT_W            = 32;

  // Pin widths.
  localparam int unsigned LEVEL_W          = 2;
  localparam int unsigned ADDR_W           = 2 * LEVEL_W;
  localparam int unsigned PIN_W            = 3 + 2 * LEVEL_W;

  // Register port.
  localparam int unsigned RA_W             = 4;
  localparam logic [RA_W-1:0] REG_STATUS   = 4'h0;
  localparam logic [RA_W-1:0] REG_CTRL     = 4'h4;
  localparam int unsigned ST_COND_LSB      = 0;
  localparam int unsigned ST_RS485_BIT     = 4;
  localparam int unsigned ST_MAIN_ON_BIT   = 5;
  localparam int unsigned ST_ADDR_LSB      = 8;
  localparam int unsigned ST_LED_LSB       = 12;
  localparam int unsigned CTRL_LAMP_BIT    = 0;
  localparam logic        CTRL_LAMP_RST    = 1'b0;

  // Displayed condition, ALE_OK first, then the rest most severe first.
  typedef enum logic [3:0] {
    ALE_OK        = 4'h0,
    ALE_THERM_SD  = 4'h1,
    ALE_LATCHED   = 4'h2,
    ALE_IN_ABSENT = 4'h3,
    ALE_IN_LIMITS = 4'h4,
    ALE_STANDBY   = 4'h5,
    ALE_OVERLOAD  = 4'h6,
    ALE_THERM_ALM = 4'h7,
    ALE_INT_FAIL  = 4'h8,
    ALE_COMM_FLT  = 4'h9,
    ALE_SVC_REQ   = 4'hA
  } ale_cond_e;

  // Internal condition flags, same clock as the encoder.
  typedef struct packed {
    logic thermal_alarm;
    logic thermal_shutdown;
    logic fuse_blown;
    logic boost_fail;
    logic ov_latched;
    logic input_out_of_limits;
    logic input_absent;
    logic overcurrent;
    logic internal_fail;
    logic service_request;
    logic comm_fault;
  } ale_flags_s;

  typedef struct packed {
    logic input_ok_led;
    logic output_ok_led;
    logic service_led;
    logic fault_led;
  } ale_led_s;

  // Open-drain alarm lines; oe high pulls the line low.
  typedef struct packed {
    logic fault_n_o;
    logic fault_n_oe;
    logic overtemp_warn_n_o;
    logic overtemp_warn_n_oe;
    logic output_health_n_o;
    logic output_health_n_oe;
    logic module_inserted_n_o;
    logic module_inserted_n_oe;
  } ale_alarm_s;

endpackage
`default_nettype wire

// ### verilog/ale_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ale_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } ale_sync_s;

  ale_sync_s st;
  ale_sync_s next_st;

  if (W < 1) begin : g_bad_w
    $error("ale_sync width must be at least one");
  end

  // The first stage feeds only the second stage.
  always_comb begin
    next_st      = st;
    next_st.meta = d;
    next_st.sync = st.meta;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.sync;

endmodule
`default_nettype wire

// ### verilog/ale_encoder.sv
// Contract
// - Alarm lines are open-drain active low, all but module present released when idle, and the normal pattern lights input ok and output ok only.
// - A thermal alarm pulls the warning line low and lights service while input ok and output ok stay lit.
// - Thermal shutdown pulls fault, warning and power good low, lights service and fault, darkens output ok.
// - Fuse, boost or latched overvoltage failure lights fault, darkens output ok and pulls fault and power good low.
// - Input out of limits blinks input ok, absent input darkens it, both pull power good low with all else off.
// - Overcurrent blinks output ok and pulses power good with a 1 ms period for as long as it lasts.
// - A non-shutdown internal failure lights fault and pulls the fault line low with both ok indicators lit.
// - In analog or PMBus mode the output runs only while output control is shorted, else remote standby shows.
// - A service request blinks service only in PMBus mode; other modes light service only for thermal warning or thermal shutdown.
// - A communications fault blinks the fault indicator only in RS485 mode with fault, warning and power good high and module present low.
// - An open protocol select pin chooses analog or PMBus mode and a strap resistor chooses RS485 mode.
// - Address bits A3 to A0 come from the first and second strapped address levels.
// - The main output is enabled only while the slot position sense sees the enabling strap.
// - Power good is pulled low whenever the main output may be lost.
// - Module present is held low in every condition while the unit is inserted.
`timescale 1ns/1ps
`default_nettype none
module ale_encoder #(
  parameter int unsigned BLINK_HALF = ale_pkg::BLINK_HALF_CYC,
  parameter int unsigned PULSE_HALF = ale_pkg::PULSE_HALF_CYC
) (
  input  wire logic                          clk,
  input  wire logic                          nrst,
  input  wire ale_pkg::ale_flags_s           flags,
  input  wire logic                          output_control_n,
  input  wire logic                          protocol_open,
  input  wire logic                          slot_position_sense,
  input  wire logic [ale_pkg::LEVEL_W-1:0]   address_level_first,
  input  wire logic [ale_pkg::LEVEL_W-1:0]   address_level_second,
  input  wire logic [ale_pkg::RA_W-1:0]      reg_addr,
  input  wire logic [31:0]                   reg_wdata,
  input  wire logic                          reg_we,
  input  wire logic                          reg_re,
  output logic      [31:0]                   reg_rdata,
  output ale_pkg::ale_led_s                  leds,
  output ale_pkg::ale_alarm_s                alarm,
  output logic                               main_output_on,
  output logic                               rs485_mode,
  output logic      [ale_pkg::ADDR_W-1:0]    i2c_addr_low
);

  typedef struct packed {
    logic [ale_pkg::CNT_W-1:0]  blink_cnt;
    logic                       blink;
    logic [ale_pkg::CNT_W-1:0]  pulse_cnt;
    logic                       pulse;
    ale_pkg::ale_cond_e         cond;
    ale_pkg::ale_led_s          led;
    ale_pkg::ale_alarm_s        alarm;
    logic                       main_on;
    logic                       rs485;
    logic [ale_pkg::ADDR_W-1:0] addr;
    logic                       lamp_test;
    logic [31:0]                rdata;
  } ale_state_s;

  ale_state_s st;
  ale_state_s next_st;

  logic [ale_pkg::PIN_W-1:0] pins_raw;
  logic [ale_pkg::PIN_W-1:0] pins_sync;
  logic                      ctl_shorted;
  logic                      proto_open_s;
  logic                      slot_ok_s;
  logic [ale_pkg::LEVEL_W-1:0] lvl_first_s;
  logic [ale_pkg::LEVEL_W-1:0] lvl_second_s;
  logic                      permit;
  logic                      pmbus;
  ale_pkg::ale_cond_e        cond_now;

  if (BLINK_HALF < 1 || PULSE_HALF < 1) begin : g_bad_count
    $error("ale_encoder blink and pulse counts must be at least one");
  end

  // Strap and control pins arrive from outside the clock domain.
  assign pins_raw = {output_control_n,
                     protocol_open,
                     slot_position_sense,
                     address_level_first,
                     address_level_second};

  ale_sync #(
    .W (ale_pkg::PIN_W)
  ) u_pin_sync (
    .clk  (clk),
    .nrst (nrst),
    .d    (pins_raw),
    .q    (pins_sync)
  );

  assign ctl_shorted  = ~pins_sync[ale_pkg::PIN_W-1];
  assign proto_open_s = pins_sync[ale_pkg::PIN_W-2];
  assign slot_ok_s    = pins_sync[ale_pkg::PIN_W-3];
  assign lvl_first_s  = pins_sync[2*ale_pkg::LEVEL_W-1:ale_pkg::LEVEL_W];
  assign lvl_second_s = pins_sync[ale_pkg::LEVEL_W-1:0];

  // An open protocol pin means analog or PMBus operation.
  assign pmbus = proto_open_s;

  // Output control only matters outside RS485 mode.
  assign permit = slot_ok_s && (!pmbus || ctl_shorted);

  // Severity order: shutdowns, then input loss, then standby, then
  // warnings and requests. Only one pattern can be shown at a time.
  always_comb begin
    if (flags.thermal_shutdown) begin
      cond_now = ale_pkg::ALE_THERM_SD;
    end else if (flags.fuse_blown || flags.boost_fail ||
                 flags.ov_latched) begin
      cond_now = ale_pkg::ALE_LATCHED;
    end else if (flags.input_absent) begin
      cond_now = ale_pkg::ALE_IN_ABSENT;
    end else if (flags.input_out_of_limits) begin
      cond_now = ale_pkg::ALE_IN_LIMITS;
    end else if (!permit) begin
      cond_now = ale_pkg::ALE_STANDBY;
    end else if (flags.overcurrent) begin
      cond_now = ale_pkg::ALE_OVERLOAD;
    end else if (flags.thermal_alarm) begin
      cond_now = ale_pkg::ALE_THERM_ALM;
    end else if (flags.internal_fail) begin
      cond_now = ale_pkg::ALE_INT_FAIL;
    end else if (flags.comm_fault && !pmbus) begin
      cond_now = ale_pkg::ALE_COMM_FLT;
    end else if (flags.service_request && pmbus) begin
      cond_now = ale_pkg::ALE_SVC_REQ;
    end else begin
      cond_now = ale_pkg::ALE_OK;
    end
  end

  always_comb begin
    next_st = st;

    // Free-running blink generator and overload-gated power-good pulse generator.
    if (st.blink_cnt >= ale_pkg::CNT_W'(BLINK_HALF - 1)) begin
      next_st.blink_cnt = '0;
      next_st.blink     = ~st.blink;
    end else begin
      next_st.blink_cnt = st.blink_cnt + 1'b1;
    end
    // The pulse restarts on each overload so every episode begins low.
    // The restart looks at the live condition so the first low phase
    // is as long as every later one.
    if (cond_now != ale_pkg::ALE_OVERLOAD) begin
      next_st.pulse_cnt = '0;
      next_st.pulse     = 1'b1;
    end else if (st.pulse_cnt >= ale_pkg::CNT_W'(PULSE_HALF - 1)) begin
      next_st.pulse_cnt = '0;
      next_st.pulse     = ~st.pulse;
    end else begin
      next_st.pulse_cnt = st.pulse_cnt + 1'b1;
    end

    next_st.cond  = cond_now;
    next_st.rs485 = ~pmbus;
    next_st.addr  = {lvl_first_s, lvl_second_s};

    next_st.main_on = permit &&
                      (cond_now != ale_pkg::ALE_THERM_SD) &&
                      (cond_now != ale_pkg::ALE_LATCHED) &&
                      (cond_now != ale_pkg::ALE_IN_ABSENT) &&
                      (cond_now != ale_pkg::ALE_IN_LIMITS);

    // Pin levels are always low when enabled; the enable carries state.
    next_st.alarm                      = '0;
    next_st.alarm.module_inserted_n_oe = 1'b1;

    // Defaults are the normal pattern.
    next_st.led.input_ok_led  = 1'b1;
    next_st.led.output_ok_led = 1'b1;
    next_st.led.service_led   = 1'b0;
    next_st.led.fault_led     = 1'b0;

    case (cond_now)
      ale_pkg::ALE_OK: begin
        next_st.led = next_st.led;
      end
      ale_pkg::ALE_THERM_ALM: begin
        next_st.led.service_led          = 1'b1;
        next_st.alarm.overtemp_warn_n_oe = 1'b1;
      end
      ale_pkg::ALE_THERM_SD: begin
        next_st.led.output_ok_led        = 1'b0;
        next_st.led.service_led          = 1'b1;
        next_st.led.fault_led            = 1'b1;
        next_st.alarm.fault_n_oe         = 1'b1;
        next_st.alarm.overtemp_warn_n_oe = 1'b1;
        next_st.alarm.output_health_n_oe = 1'b1;
      end
      ale_pkg::ALE_LATCHED: begin
        next_st.led.output_ok_led        = 1'b0;
        next_st.led.fault_led            = 1'b1;
        next_st.alarm.fault_n_oe         = 1'b1;
        next_st.alarm.output_health_n_oe = 1'b1;
      end
      ale_pkg::ALE_IN_LIMITS: begin
        next_st.led.input_ok_led         = st.blink;
        next_st.led.output_ok_led        = 1'b0;
        next_st.alarm.output_health_n_oe = 1'b1;
      end
      ale_pkg::ALE_IN_ABSENT: begin
        next_st.led.input_ok_led         = 1'b0;
        next_st.led.output_ok_led        = 1'b0;
        next_st.alarm.output_health_n_oe = 1'b1;
      end
      ale_pkg::ALE_STANDBY: begin
        next_st.led.output_ok_led        = 1'b0;
        next_st.alarm.output_health_n_oe = 1'b1;
      end
      ale_pkg::ALE_OVERLOAD: begin
        next_st.led.output_ok_led        = st.blink;
        next_st.alarm.output_health_n_oe = st.pulse;
      end
      ale_pkg::ALE_INT_FAIL: begin
        next_st.led.fault_led    = 1'b1;
        next_st.alarm.fault_n_oe = 1'b1;
      end
      ale_pkg::ALE_COMM_FLT: begin
        next_st.led.fault_led = st.blink;
      end
      ale_pkg::ALE_SVC_REQ: begin
        next_st.led.service_led = st.blink;
      end
      default: begin
        next_st.led = next_st.led;
      end
    endcase

    // Lamp test lights every indicator but never touches the alarm lines.
    if (st.lamp_test) begin
      next_st.led = '1;
    end

    if (reg_we && reg_addr == ale_pkg::REG_CTRL) begin
      next_st.lamp_test = reg_wdata[ale_pkg::CTRL_LAMP_BIT];
    end

    // Read data stand for exactly one cycle after the strobe.
    next_st.rdata = '0;
    if (reg_re) begin
      case (reg_addr)
        ale_pkg::REG_STATUS: begin
          next_st.rdata[ale_pkg::ST_COND_LSB +: 4]       = st.cond;
          next_st.rdata[ale_pkg::ST_RS485_BIT]           = st.rs485;
          next_st.rdata[ale_pkg::ST_MAIN_ON_BIT]         = st.main_on;
          next_st.rdata[ale_pkg::ST_ADDR_LSB +:
                        ale_pkg::ADDR_W]                 = st.addr;
          next_st.rdata[ale_pkg::ST_LED_LSB +: 4]        = st.led;
        end
        ale_pkg::REG_CTRL: begin
          next_st.rdata[ale_pkg::CTRL_LAMP_BIT] = st.lamp_test;
        end
        default: begin
          next_st.rdata = '0;
        end
      endcase
    end
  end

  // Reset shows a unit with no output yet: power good pulled low,
  // presence asserted, other lines released and indicators dark.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st                          <= '0;
      st.cond                     <= ale_pkg::ALE_STANDBY;
      st.pulse                    <= 1'b1;
      st.alarm.output_health_n_oe <= 1'b1;
      st.alarm.module_inserted_n_oe <= 1'b1;
      st.lamp_test                <= ale_pkg::CTRL_LAMP_RST;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata      = st.rdata;
  assign leds           = st.led;
  assign alarm          = st.alarm;
  assign main_output_on = st.main_on;
  assign rs485_mode     = st.rs485;
  assign i2c_addr_low   = st.addr;

endmodule
`default_nettype wire

// ### sim/ale_encoder_properties.sv
`timescale 1ns/1ps
`default_nettype none
module ale_encoder_chk #(
  parameter int unsigned BLINK_HALF = 8,
  parameter int unsigned PULSE_HALF = 4
) (
  input wire logic                        clk,
  input wire logic                        nrst,
  input wire ale_pkg::ale_flags_s         flags,
  input wire logic                        output_control_n,
  input wire logic                        protocol_open,
  input wire logic                        slot_position_sense,
  input wire logic [ale_pkg::LEVEL_W-1:0] address_level_first,
  input wire logic [ale_pkg::LEVEL_W-1:0] address_level_second,
  input wire logic [ale_pkg::RA_W-1:0]    reg_addr,
  input wire logic                        reg_re,
  input wire logic [31:0]                 reg_rdata,
  input wire ale_pkg::ale_alarm_s         alarm,
  input wire logic                        main_output_on,
  input wire logic                        rs485_mode,
  input wire logic [ale_pkg::ADDR_W-1:0]  i2c_addr_low
);
  logic [2:0]  up_q;
  logic [31:0] hc_q;
  logic        ho_q;
  wire logic   sd  = flags.thermal_shutdown;
  wire logic   lat = flags.fuse_blown | flags.boost_fail | flags.ov_latched;
  wire logic   inl = flags.input_absent | flags.input_out_of_limits;
  wire logic   oc  = flags.overcurrent & ~sd & ~lat & ~inl;
  wire logic   chg = ho_q != alarm.output_health_n_oe;

  // Run length of the power-good level; restarts outside a running overload.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      up_q <= 3'h0;
      hc_q <= 32'h0;
      ho_q <= 1'b0;
    end else begin
      up_q <= (up_q == 3'h7) ? up_q : up_q + 3'h1;
      ho_q <= alarm.output_health_n_oe;
      hc_q <= (!oc || !main_output_on || chg) ? 32'h0 : hc_q + 32'h1;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_present_held: assert property (alarm.module_inserted_n_oe
    && !alarm.module_inserted_n_o && !alarm.fault_n_o)
    else $error("module present line released");
  a_shutdown_lines: assert property (sd |=> alarm.fault_n_oe
    && alarm.overtemp_warn_n_oe && alarm.output_health_n_oe
    && !main_output_on)
    else $error("shutdown lines wrong");
  a_latched_lines: assert property (lat && !sd |=> alarm.fault_n_oe
    && !alarm.overtemp_warn_n_oe && alarm.output_health_n_oe)
    else $error("latched failure lines wrong");
  a_input_lines: assert property (inl && !sd && !lat |=>
    alarm.output_health_n_oe && !alarm.fault_n_oe && !main_output_on)
    else $error("input loss lines wrong");
  a_warn_line: assert property (flags.thermal_alarm && !sd && !lat
    && !inl && !flags.overcurrent |=> !main_output_on ||
    (alarm.overtemp_warn_n_oe && !alarm.fault_n_oe
    && !alarm.output_health_n_oe))
    else $error("thermal warning lines wrong");
  a_idle_lines: assert property (flags == '0 |=> !alarm.fault_n_oe
    && !alarm.overtemp_warn_n_oe && main_output_on != alarm.output_health_n_oe)
    else $error("idle lines wrong");
  a_pulse_run: assert property (hc_q <= PULSE_HALF)
    else $error("power good pulse stuck");
  a_standby_gate: assert property ((up_q == 3'h7 &&
    (!slot_position_sense || (output_control_n && protocol_open)))[*5]
    |-> !main_output_on) else $error("output on without permission");
  a_mode_select: assert property ((up_q == 3'h7 &&
    $stable(protocol_open))[*4] |-> rs485_mode == !protocol_open)
    else $error("mode select wrong");
  a_addr_strap: assert property ((up_q == 3'h7 && $stable({
    address_level_first, address_level_second}))[*4] |->
    i2c_addr_low == {address_level_first, address_level_second})
    else $error("address strap wrong");
  a_rdata_idle: assert property (!$past(reg_re) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  a_unmapped_read: assert property (reg_re && reg_addr != ale_pkg::REG_STATUS
    && reg_addr != ale_pkg::REG_CTRL |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");

  c_shutdown: cover property (sd ##1 alarm.fault_n_oe);
  c_overload: cover property (oc && main_output_on && chg);
  c_comm: cover property (rs485_mode && flags.comm_fault);
endmodule

bind ale_encoder ale_encoder_chk #(
  .BLINK_HALF (BLINK_HALF),
  .PULSE_HALF (PULSE_HALF)
) ale_encoder_chk_i (
  .clk (clk), .nrst (nrst), .flags (flags),
  .output_control_n (output_control_n), .protocol_open (protocol_open),
  .slot_position_sense (slot_position_sense),
  .address_level_first (address_level_first),
  .address_level_second (address_level_second),
  .reg_addr (reg_addr), .reg_re (reg_re), .reg_rdata (reg_rdata),
  .alarm (alarm), .main_output_on (main_output_on),
  .rs485_mode (rs485_mode), .i2c_addr_low (i2c_addr_low)
);
`default_nettype wire

// ### sim/ale_shelf_model.sv
`timescale 1ns/1ps
`default_nettype none
module ale_shelf_model (
  input  wire ale_pkg::ale_alarm_s alarm,
  output logic [3:0]               line_n
);
  // Pull-ups make a released line read high, never a held last value.
  assign line_n[3] = alarm.fault_n_oe ? alarm.fault_n_o : 1'b1;
  assign line_n[2] = alarm.overtemp_warn_n_oe ?
                     alarm.overtemp_warn_n_o : 1'b1;
  assign line_n[1] = alarm.output_health_n_oe ?
                     alarm.output_health_n_o : 1'b1;
  assign line_n[0] = alarm.module_inserted_n_oe ?
                     alarm.module_inserted_n_o : 1'b1;
endmodule
`default_nettype wire

// ### sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int unsigned BH = 8;
  localparam int unsigned PH = 4;
  logic                clk, nrst, ocn, popen, slot, we, re, mon, rs;
  logic [1:0]          lv1, lv2;
  logic [3:0]          ra, addr, line_n;
  logic [31:0]         wd, rd, d;
  ale_pkg::ale_flags_s flags;
  ale_pkg::ale_led_s   leds;
  ale_pkg::ale_alarm_s alarm;
  int                  bad_count, n_tests;

  ale_encoder #(.BLINK_HALF(BH), .PULSE_HALF(PH)) ale_encoder_i (
    .clk(clk), .nrst(nrst), .flags(flags), .output_control_n(ocn),
    .protocol_open(popen), .slot_position_sense(slot),
    .address_level_first(lv1), .address_level_second(lv2), .reg_addr(ra),
    .reg_wdata(wd), .reg_we(we), .reg_re(re), .reg_rdata(rd), .leds(leds),
    .alarm(alarm), .main_output_on(mon), .rs485_mode(rs), .i2c_addr_low(addr));
  ale_shelf_model ale_shelf_model_i (.alarm(alarm), .line_n(line_n));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    we <= 1'b1;
    ra <= a;
    wd <= v;
    @(posedge clk);
    we <= 1'b0;
  endtask

  task automatic rdr(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    re <= 1'b1;
    ra <= a;
    @(posedge clk);
    re <= 1'b0;
    #1 v = rd;
  endtask

  // Leds {in,out,svc,flt} and lines {fault,warn,pg,present}; a blinking
  // bit must be seen low and high, so its low bound is 0 and high bound 1.
  function automatic logic [15:0] model(input ale_pkg::ale_flags_s f,
                                        input logic r, p);
    logic [3:0] l, b, a, q;
    b = 4'h0;
    q = 4'h0;
    if (f.thermal_shutdown) begin
      l = 4'hB; a = 4'h0;
    end else if (f.fuse_blown | f.boost_fail | f.ov_latched) begin
      l = 4'h9; a = 4'h4;
    end else if (f.input_absent) begin
      l = 4'h0; a = 4'hC;
    end else if (f.input_out_of_limits) begin
      l = 4'h0; b = 4'h8; a = 4'hC;
    end else if (!p) begin
      l = 4'h8; a = 4'hC;
    end else if (f.overcurrent) begin
      l = 4'h8; b = 4'h4; a = 4'hC; q = 4'h2;
    end else if (f.thermal_alarm) begin
      l = 4'hE; a = 4'hA;
    end else if (f.internal_fail) begin
      l = 4'hD; a = 4'h6;
    end else if (f.comm_fault && r) begin
      l = 4'hC; b = 4'h1; a = 4'hE;
    end else if (f.service_request && !r) begin
      l = 4'hC; b = 4'h2; a = 4'hE;
    end else begin
      l = 4'hC; a = 4'hE;
    end
    return {l & ~b, l | b, a & ~q, a | q};
  endfunction

  task automatic run_case(input ale_pkg::ale_flags_s f, input logic po, oc, sl);
    logic [3:0] la, lo, na, no;
    logic [15:0] e;
    logic       perm, on;
    @(posedge clk);
    flags <= f;
    popen <= po;
    ocn <= oc;
    slot <= sl;
    lv1 <= 2'($urandom);
    lv2 <= 2'($urandom);
    perm = sl && (!po || !oc);
    on = perm && !(f.thermal_shutdown | f.fuse_blown | f.boost_fail
         | f.ov_latched | f.input_absent | f.input_out_of_limits);
    repeat (6) @(posedge clk);
    #1;
    {la, lo, na, no} = 16'hF0F0;
    repeat (20) begin
      la &= leds;
      lo |= leds;
      na &= line_n;
      no |= line_n;
      @(posedge clk);
      #1;
    end
    e = model(f, !po, perm);
    chk("led low", e[15:12], la);
    chk("led high", e[11:8], lo);
    chk("line low", e[7:4], na);
    chk("line high", e[3:0], no);
    chk("pins", {on, !po, lv1, lv2}, {mon, rs, addr});
    rdr(ale_pkg::REG_STATUS, d);
    chk("status", {on, !po, lv1, lv2}, {d[5:4], d[11:8]});
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    test_done();
  end

  initial begin
    {nrst, ocn, we, re, lv1, lv2, ra, wd} = '0;
    {popen, slot} = 2'h3;
    flags = '0;
    void'($urandom(78832));
    repeat (8) @(posedge clk);
    #1 chk("reset", 16'h0005, {leds, 3'h0, mon, alarm});
    nrst <= 1'b1;
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 11; i++) begin
        run_case(ale_pkg::ale_flags_s'(11'h001 << i), m[0], 1'b0, 1'b1);
      end
    end
    run_case(ale_pkg::ale_flags_s'(11'h010), 1'b1, 1'b1, 1'b1);
    run_case(ale_pkg::ale_flags_s'(11'h001), 1'b0, 1'b1, 1'b1);
    run_case(ale_pkg::ale_flags_s'(11'h000), 1'b0, 1'b0, 1'b0);
    run_case(ale_pkg::ale_flags_s'(11'h000), 1'b1, 1'b0, 1'b1);
    wr(ale_pkg::REG_CTRL, 32'h1);
    wr(4'hC, 32'h0);
    repeat (2) @(posedge clk);
    #1 chk("lamp", 16'h00FE, {8'h0, leds, line_n});
    rdr(ale_pkg::REG_CTRL, d);
    chk("ctrl", 16'h0001, d[15:0]);
    rdr(4'h8, d);
    chk("unmapped", 16'h0000, d[15:0] | d[31:16]);
    wr(ale_pkg::REG_CTRL, 32'h0);
    repeat (40) begin
      run_case(ale_pkg::ale_flags_s'($urandom & $urandom & $urandom),
               1'($urandom), 1'($urandom), ($urandom % 4) != 0);
    end
    test_done();
  end
endmodule
`default_nettype wire
